//--- hdl/tpio_edge.sv
// edge detector for one synchronous timer pin input
`timescale 1ns/1ps
`default_nettype none

module tpio_edge (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pin_in,
  output logic rise,
  output logic fall
);

  logic prev_ff;

  // ----------------------------------------------------------------------------
  // previous pin level
  // ----------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_ff <= 1'b0;
    end else begin
      prev_ff <= pin_in;
    end
  end

  // edge pulses, one cycle each
  assign rise = pin_in & ~prev_ff;
  assign fall = ~pin_in & prev_ff;

endmodule // tpio_edge

`default_nettype wire

//--- hdl/tpio_top.sv
// pin i/o control for channel 0 register c and channel 1 register a
`timescale 1ns/1ps
`default_nettype none
`include "tpio_defs.svh"

module tpio_top
  import tpio_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [CNT_W-1:0] ch0_counter,
  input wire logic [CNT_W-1:0] ch1_counter,
  input wire logic ch1_count_step,
  input wire logic ch0_rega_event,
  input wire logic ch0_pin_c_in,
  output logic ch0_pin_c_out,
  output logic ch0_pin_c_oe_n,
  input wire logic ch1_pin_a_in,
  output logic ch1_pin_a_out,
  output logic ch1_pin_a_oe_n
);

  // ----------------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------------
  tpio_ctl_t ctrl_ff [2];
  logic [CNT_W-1:0] gr_ff [2];
  logic [CNT_W-1:0] cnt [2];
  logic [1:0] pin_ff;
  logic [`TPIO_ST_FLAG_W-1:0] flags_ff;
  logic [`TPIO_ST_FLAG_W-1:0] nxt_flags;
  logic buf_ff;
  logic written_ff;
  logic [31:0] prdata_ff;
  logic [31:0] nxt_prdata;
  logic [1:0] rise;
  logic [1:0] fall;
  logic [1:0] alt_ev;
  logic [1:0] inhibit;
  logic [1:0] cap_mode;
  logic [1:0] match;
  logic [1:0] cap_ev;
  logic [1:0] ctl_wr;
  logic [1:0] gr_wr;
  logic wr_en;
  logic addr_hit;
  logic new_cmp_drive;

  // ----------------------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------------------
  // true when the bus address is the given register offset
  function automatic logic addr_is(input logic [7:0] addr, input logic [7:0] off);
    return addr == off;
  endfunction

  // capture trigger select from the three code bits
  function automatic logic cap_hit(
    input logic [2:0] code,
    input logic r,
    input logic f,
    input logic alt
  );
    logic hit;
    hit = 1'b0;
    if (code[2]) begin
      hit = alt;
    end else if (code[1]) begin
      hit = r | f;
    end else if (code[0]) begin
      hit = f;
    end else begin
      hit = r;
    end
    return hit;
  endfunction

  // next pin level on a compare match
  function automatic logic cmp_next(input logic [1:0] act, input logic cur);
    logic nxt;
    nxt = cur;
    case (tpio_cmp_act_t'(act))
      TPIO_ACT_LOW: nxt = 1'b0;
      TPIO_ACT_HIGH: nxt = 1'b1;
      TPIO_ACT_TOGGLE: nxt = ~cur;
      default: nxt = cur;
    endcase
    return nxt;
  endfunction

  // ----------------------------------------------------------------------------
  // pin edge detection
  // ----------------------------------------------------------------------------
  tpio_edge u_edge0 (
    .pclk(pclk),
    .presetn(presetn),
    .pin_in(ch0_pin_c_in),
    .rise(rise[0]),
    .fall(fall[0])
  );

  tpio_edge u_edge1 (
    .pclk(pclk),
    .presetn(presetn),
    .pin_in(ch1_pin_a_in),
    .rise(rise[1]),
    .fall(fall[1])
  );

  // ----------------------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------------------
  // zero wait state slave, error on unmapped offsets
  assign pready = 1'b1;
  assign wr_en = psel & penable & pwrite;
  assign addr_hit = addr_is(paddr, `TPIO_OFF_CH0_CTL) | addr_is(paddr, `TPIO_OFF_CH1_CTL) |
                    addr_is(paddr, `TPIO_OFF_MODE) | addr_is(paddr, `TPIO_OFF_CH0_GRC) |
                    addr_is(paddr, `TPIO_OFF_CH1_GRA) | addr_is(paddr, `TPIO_OFF_STATUS);
  assign pslverr = psel & penable & ~addr_hit;
  assign ctl_wr[0] = wr_en & addr_is(paddr, `TPIO_OFF_CH0_CTL);
  assign ctl_wr[1] = wr_en & addr_is(paddr, `TPIO_OFF_CH1_CTL);
  assign gr_wr[0] = wr_en & addr_is(paddr, `TPIO_OFF_CH0_GRC);
  assign gr_wr[1] = wr_en & addr_is(paddr, `TPIO_OFF_CH1_GRA);
  // written code asks for an initial drive level
  assign new_cmp_drive = ~pwdata[`TPIO_CTL_MODE_BIT] & (pwdata[1:0] != 2'h0);

  // ----------------------------------------------------------------------------
  // per channel event logic
  // ----------------------------------------------------------------------------
  assign cnt[0] = ch0_counter;
  assign cnt[1] = ch1_counter;
  assign alt_ev[0] = ch1_count_step;
  assign alt_ev[1] = ch0_rega_event;
  assign inhibit[0] = buf_ff;
  assign inhibit[1] = 1'b0;
  // match and capture strobes
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      cap_mode[i] = ctrl_ff[i][`TPIO_CTL_MODE_BIT];
      match[i] = ~cap_mode[i] & ~inhibit[i] & (cnt[i] == gr_ff[i]);
      cap_ev[i] = cap_mode[i] & ~inhibit[i] &
                  cap_hit(ctrl_ff[i][2:0], rise[i], fall[i], alt_ev[i]);
    end
  end

  // ----------------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------------
  // pin i/o control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff[0] <= `TPIO_CTL_RST;
      ctrl_ff[1] <= `TPIO_CTL_RST;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (ctl_wr[i]) begin
          ctrl_ff[i] <= pwdata[`TPIO_CTL_W-1:0];
        end
      end
    end
  end

  // buffer operation select
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buf_ff <= `TPIO_MODE_RST;
    end else if (wr_en && addr_is(paddr, `TPIO_OFF_MODE)) begin
      buf_ff <= pwdata[`TPIO_MODE_BUF_BIT];
    end
  end

  // general registers, capture beats a software write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gr_ff[0] <= '0;
      gr_ff[1] <= '0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (cap_ev[i]) begin
          gr_ff[i] <= cnt[i];
        end else if (gr_wr[i]) begin
          gr_ff[i] <= pwdata[CNT_W-1:0];
        end
      end
    end
  end

  // pin levels, a control write overrides a match in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_ff <= {2{`TPIO_PIN_RST}};
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (ctl_wr[i]) begin
          if (new_cmp_drive) begin
            pin_ff[i] <= pwdata[`TPIO_CTL_INIT_BIT];
          end
        end else if (match[i]) begin
          pin_ff[i] <= cmp_next(ctrl_ff[i][1:0], pin_ff[i]);
        end
      end
    end
  end

  // sticky event flags, write one to clear, set wins
  always_comb begin
    nxt_flags = flags_ff;
    if (wr_en && addr_is(paddr, `TPIO_OFF_STATUS)) begin
      nxt_flags = flags_ff & ~pwdata[`TPIO_ST_FLAG_W-1:0];
    end
    nxt_flags = nxt_flags | {cap_ev[1], match[1], cap_ev[0], match[0]};
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_ff <= `TPIO_FLAG_RST;
    end else begin
      flags_ff <= nxt_flags;
    end
  end

  // first control write seen
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      written_ff <= 1'b0;
    end else if (ctl_wr != 2'b00) begin
      written_ff <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------------------
  // read mux, reserved bits zero
  always_comb begin
    nxt_prdata = 32'h0;
    case (paddr)
      `TPIO_OFF_CH0_CTL: nxt_prdata = {28'h0, ctrl_ff[0]};
      `TPIO_OFF_CH1_CTL: nxt_prdata = {28'h0, ctrl_ff[1]};
      `TPIO_OFF_MODE: nxt_prdata = {31'h0, buf_ff};
      `TPIO_OFF_CH0_GRC: nxt_prdata = {{(32-CNT_W){1'b0}}, gr_ff[0]};
      `TPIO_OFF_CH1_GRA: nxt_prdata = {{(32-CNT_W){1'b0}}, gr_ff[1]};
      `TPIO_OFF_STATUS: nxt_prdata = {26'h0, pin_ff, flags_ff};
      default: nxt_prdata = 32'h0;
    endcase
  end

  // read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0;
    end else if (psel && !penable && !pwrite) begin
      prdata_ff <= nxt_prdata;
    end
  end

  // ----------------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------------
  assign prdata = prdata_ff;
  assign ch0_pin_c_out = pin_ff[0];
  assign ch1_pin_a_out = pin_ff[1];
  assign ch0_pin_c_oe_n = ctrl_ff[0][`TPIO_CTL_MODE_BIT]; // released in capture mode
  assign ch1_pin_a_oe_n = ctrl_ff[1][`TPIO_CTL_MODE_BIT];

  // ----------------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_cmp(int ch, logic [1:0] act);
    match[ch] && !ctl_wr[ch] && ctrl_ff[ch][1:0] == act;
  endsequence
  sequence s_cap0(logic [2:0] code);
    cap_mode[0] && !inhibit[0] && ctrl_ff[0][2:0] == code;
  endsequence
  a_init_level: assert property (ctl_wr[0] && new_cmp_drive |=>
      pin_ff[0] == $past(pwdata[`TPIO_CTL_INIT_BIT]))
    else $error("initial pin level wrong");
  a_match_low: assert property (s_cmp(0, 2'h1) |=> !pin_ff[0])
    else $error("pin not low after match");
  a_match_high: assert property (s_cmp(1, 2'h2) |=> pin_ff[1])
    else $error("pin not high after match");
  a_match_toggle: assert property (s_cmp(1, 2'h3) |=> pin_ff[1] != $past(pin_ff[1]))
    else $error("pin not inverted after match");
  a_reset_low: assert property (!written_ff |-> pin_ff == 2'b00 && ch0_pin_c_oe_n == 1'b0)
    else $error("pin not low before first write");
  a_cap_rise: assert property (s_cap0(3'h0) ##0 rise[0] |=> gr_ff[0] == $past(cnt[0]))
    else $error("rising edge capture missed");
  a_cap_fall: assert property (s_cap0(3'h1) ##0 fall[0] |=> gr_ff[0] == $past(cnt[0]))
    else $error("falling edge capture missed");
  a_cap_both: assert property (s_cap0(3'h2) ##0 (rise[0] || fall[0]) |=>
      gr_ff[0] == $past(cnt[0]))
    else $error("both edge capture missed");
  a_cap_step: assert property (cap_mode[0] && ctrl_ff[0][2] && !inhibit[0] &&
      ch1_count_step |-> cap_ev[0] ##1 flags_ff[1])
    else $error("count step capture missed");
  a_cap_cross: assert property (cap_mode[1] && ctrl_ff[1][2] && ch0_rega_event |=>
      gr_ff[1] == $past(cnt[1]) && flags_ff[3])
    else $error("cross channel capture missed");
  a_buf_block: assert property (inhibit[0] && !gr_wr[0] && !ctl_wr[0] |=>
      $stable(gr_ff[0]) && $stable(pin_ff[0]))
    else $error("event while buffer operation on");
  a_hold_code: assert property (!cap_mode[1] && ctrl_ff[1][1:0] == 2'h0 && !ctl_wr[1] |=>
      $stable(pin_ff[1]))
    else $error("pin moved under hold code");
  a_match_equal: assert property ($rose(flags_ff[0]) |->
      $past(cnt[0]) == $past(gr_ff[0]) && !$past(cap_mode[0]))
    else $error("match flag without equality");

endmodule // tpio_top

`default_nettype wire

//--- include/tpio_defs.svh
// register offsets, field positions and reset values of the pin i/o control block
`ifndef TPIO_DEFS_SVH
`define TPIO_DEFS_SVH

// ----------------------------------------------------------------------------
// byte offsets on the apb bus
// ----------------------------------------------------------------------------
`define TPIO_OFF_CH0_CTL 8'h00
`define TPIO_OFF_CH1_CTL 8'h04
`define TPIO_OFF_MODE 8'h08
`define TPIO_OFF_CH0_GRC 8'h0c
`define TPIO_OFF_CH1_GRA 8'h10
`define TPIO_OFF_STATUS 8'h14

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define TPIO_CTL_W 4
`define TPIO_CTL_INIT_BIT 2
`define TPIO_CTL_MODE_BIT 3
`define TPIO_MODE_BUF_BIT 0
`define TPIO_ST_FLAG_W 4
`define TPIO_ST_PIN_LSB 4

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define TPIO_CTL_RST 4'h0
`define TPIO_MODE_RST 1'b0
`define TPIO_FLAG_RST 4'h0
`define TPIO_PIN_RST 1'b0

`endif

//--- include/tpio_pkg.sv
// types shared by the pin i/o control block
package tpio_pkg;

  // --------------------------------------------------------------------------
  // compare-match pin action, low two code bits
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    TPIO_ACT_HOLD = 2'h0,
    TPIO_ACT_LOW = 2'h1,
    TPIO_ACT_HIGH = 2'h2,
    TPIO_ACT_TOGGLE = 2'h3
  } tpio_cmp_act_t;

  typedef logic [3:0] tpio_ctl_t;

endpackage

//--- testbench/timer_pin_io_control_tb.sv
// self-checking bench of the pin i/o control block
`timescale 1ns/1ps
`default_nettype none

module timer_pin_io_control_tb;
  logic pclk, presetn, psel, penable, pwrite, err, step, ev;
  logic [7:0] paddr;
  logic [31:0] pwdata, rd;
  logic [15:0] cnt;
  logic [1:0] ext, pexp;
  wire [31:0] prdata;
  wire pready, pslverr;
  wire [1:0] pin_in, pout, oe_n;
  int n_errors, check_count, cyc, seed;

  // -------------------------------------------------------------------------
  // design, pin models, clock
  // -------------------------------------------------------------------------
  tpio_top #(.CNT_W(16)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .ch0_counter(cnt),
    .ch1_counter(~cnt), .ch1_count_step(step), .ch0_rega_event(ev),
    .ch0_pin_c_in(pin_in[0]), .ch0_pin_c_out(pout[0]), .ch0_pin_c_oe_n(oe_n[0]),
    .ch1_pin_a_in(pin_in[1]), .ch1_pin_a_out(pout[1]), .ch1_pin_a_oe_n(oe_n[1]));
  tpio_pin_model M0 (.oe_n(oe_n[0]), .drv(pout[0]), .ext(ext[0]), .pin(pin_in[0]));
  tpio_pin_model M1 (.oe_n(oe_n[1]), .drv(pout[1]), .ext(ext[1]), .pin(pin_in[1]));

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // hang guard
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      final_report();
    end
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_pin(input int ch);
    check_count++;
    if (pout[ch] !== pexp[ch]) begin
      n_errors++;
      $display("unexpected at %0t: got %h exp %h", $time, pout[ch], pexp[ch]);
    end
  endtask

  task automatic wait_clk(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // one apb transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // compare code, then a one-cycle match
  task automatic cmp_run(input int ch, input logic [2:0] code, input logic inh);
    logic [15:0] v;
    logic [7:0] base;
    v = 16'($random(seed));
    base = ch ? 8'h04 : 8'h00;
    cnt <= ch ? v : ~v;
    apb(1'b1, base + 8'h0c, {16'h0, v});
    apb(1'b1, base, {29'h0, code});
    if (code[1:0] != 2'h0) pexp[ch] = code[2];
    wait_clk(1);
    chk_pin(ch);
    chk({31'h0, oe_n[ch]}, 32'h0);
    apb(1'b1, 8'h08, {31'h0, inh});
    cnt <= ch ? ~v : v;
    wait_clk(1);
    cnt <= ch ? v : ~v;
    if (!inh) begin
      case (code[1:0])
        2'h1: pexp[ch] = 1'b0;
        2'h2: pexp[ch] = 1'b1;
        2'h3: pexp[ch] = ~pexp[ch];
        default: ;
      endcase
    end
    wait_clk(1);
    chk_pin(ch);
    $display("test compare ch%0d code %h done", ch, code);
  endtask

  // capture code: a first stimulus that loads only under a both-edge code, then one that must
  task automatic cap_run(input int ch, input logic [2:0] code, input logic lvl,
                         input logic both);
    logic [15:0] g, c1, c2;
    logic [7:0] base;
    g = 16'($random(seed));
    c1 = 16'($random(seed));
    c2 = 16'($random(seed));
    base = ch ? 8'h04 : 8'h00;
    ext[ch] <= lvl;
    apb(1'b1, base, {28'h0, 1'b1, code});
    apb(1'b1, base + 8'h0c, {16'h0, g});
    chk({31'h0, oe_n[ch]}, 32'h1);
    cnt <= ch ? ~c1 : c1;
    ext[ch] <= ~lvl;
    wait_clk(3);
    apb(1'b0, base + 8'h0c, 32'h0);
    chk(rd, {16'h0, both ? c1 : g});
    cnt <= ch ? ~c2 : c2;
    if (code[2]) begin
      if (ch) ev <= 1'b1;
      else step <= 1'b1;
      wait_clk(1);
      ev <= 1'b0;
      step <= 1'b0;
    end else
      ext[ch] <= lvl;
    wait_clk(3);
    apb(1'b0, base + 8'h0c, 32'h0);
    chk(rd, {16'h0, c2});
    $display("test capture ch%0d code %h done", ch, code);
  endtask

  // -------------------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------------------
  initial begin
    seed = 92;
    {psel, penable, pwrite, step, ev, presetn} = 6'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    cnt = 16'h0;
    ext = 2'h0;
    pexp = 2'h0;
    wait_clk(8);
    presetn <= 1'b1;
    wait_clk(2);
    chk_pin(0);
    chk_pin(1);
    apb(1'b0, 8'h18, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    $display("test reset done");
    for (int ch = 0; ch < 2; ch++)
      for (int k = 1; k < 9; k++) cmp_run(ch, k[2:0], 1'b0);
    for (int i = 0; i < 6; i++) cmp_run(i % 2, 3'($random(seed)), 1'b0);
    cmp_run(0, 3'h3, 1'b1);
    apb(1'b1, 8'h08, 32'h0);
    cap_run(0, 3'h0, 1'b1, 1'b0);
    cap_run(1, 3'h0, 1'b1, 1'b0);
    cap_run(0, 3'h1, 1'b0, 1'b0);
    cap_run(1, 3'h1, 1'b0, 1'b0);
    cap_run(0, 3'h2, 1'b0, 1'b1);
    cap_run(1, 3'h3, 1'b1, 1'b1);
    cap_run(0, 3'h4, 1'b0, 1'b0);
    cap_run(1, 3'h7, 1'b1, 1'b0);
    final_report();
  end
endmodule // timer_pin_io_control_tb

`default_nettype wire

//--- testbench/tpio_pin_model.sv
// far-side model of one timer pin
`timescale 1ns/1ps
`default_nettype none

module tpio_pin_model (
  input wire logic oe_n,
  input wire logic drv,
  input wire logic ext,
  output logic pin
);
  // -------------------------------------------------------------------------
  // wire level
  // -------------------------------------------------------------------------
  // block drive when enabled, else the far-side level
  assign pin = oe_n ? ext : drv;
endmodule // tpio_pin_model

`default_nettype wire
